/* File: pfbi_host.sv */
// Host controller driving a parallel boot-sector flash through its pins
// Assumes a 100 MHz clock and the flash pins joined by the testbench
`include "pfbi_consts.svh"
// Overview of operation
// - Reads drive chip select and output enable low, write strobe high.
// - Writes drive write strobe and chip select low, output enable high.
// - After standby, wait full select access time before using read data.
// - After an aborted operation the host does not reissue it; the user must.
// - Host waits reset recovery time after reset release before reading.
`timescale 1ns/1ns
module pfbi_host (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic byte_mode_i,
  input wire logic boot_top_i,
  input wire logic rd_req_i,
  input wire logic wr_req_i,
  input wire logic flash_reset_req_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] dq_in_i,
  input wire logic ready_busy_n_i,
  output logic busy_o,
  output logic rd_valid_o,
  output logic wr_done_o,
  output logic [15:0] rdata_o,
  output logic [4:0] sector_o,
  output logic flash_busy_o,
  output logic chip_sel_n_o,
  output logic out_en_n_o,
  output logic wr_strobe_n_o,
  output logic flash_reset_n_o,
  output logic width_word_o,
  output logic [18:0] addr_o,
  output logic [15:0] dq_out_o,
  output logic [15:0] dq_oe_o
);
  pfbi_pkg::pfbi_state_type state_reg;
  pfbi_pkg::pfbi_state_type state_next;
  logic [`PFBI_CNT_W-1:0] count_reg;
  logic [`PFBI_CNT_W-1:0] count_next;
  logic ready_sync;
  logic recovery_reg;

  // Sector number from upper address bits, per boot layout
  function automatic logic [4:0] sector_of(input logic [6:0] hi, input logic top);
    logic [4:0] s;
    s = 5'h00;
    if (top) begin
      if (hi[6:3] != 4'hF) s = {1'b0, hi[6:3]};
      else if (!hi[2]) s = 5'h0F;
      else if (hi[1]) s = 5'h12;
      else s = hi[0] ? 5'h11 : 5'h10;
    end else begin
      if (hi[6:3] != 4'h0) s = 5'(hi[6:3]) + 5'h03;
      else if (hi[2]) s = 5'h03;
      else if (!hi[1]) s = 5'h00;
      else s = hi[0] ? 5'h02 : 5'h01;
    end
    return s;
  endfunction : sector_of

  pfbi_sync u_ready_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(ready_busy_n_i),
    .level_o(ready_sync)
  );

  always_comb begin
    state_next = state_reg;
    count_next = count_reg - `PFBI_CNT_W'(1);
    case (state_reg)
      pfbi_pkg::PFBI_IDLE: begin
        count_next = (count_reg != `PFBI_CNT_W'(0)) ? count_reg - `PFBI_CNT_W'(1) : count_reg;
        if (flash_reset_req_i) begin
          state_next = pfbi_pkg::PFBI_RST_PULSE;
          count_next = `PFBI_CNT_W'(`PFBI_RESET_PULSE_MIN_CYC);
        end else if (wr_req_i) begin
          state_next = pfbi_pkg::PFBI_WR_SETUP;
          count_next = `PFBI_CNT_W'(`PFBI_SETUP_CYC);
        end else if (rd_req_i && !recovery_reg) begin
          state_next = pfbi_pkg::PFBI_RD_ACCESS;
          count_next = `PFBI_CNT_W'(`PFBI_ACCESS_CYC);
        end
      end
      pfbi_pkg::PFBI_RD_ACCESS: begin
        if (count_reg == 0) begin
          state_next = pfbi_pkg::PFBI_IDLE;
          count_next = `PFBI_CNT_W'(0);
        end
      end
      pfbi_pkg::PFBI_WR_SETUP: begin
        if (count_reg == 0) begin
          state_next = pfbi_pkg::PFBI_WR_PULSE;
          count_next = `PFBI_CNT_W'(`PFBI_WE_PULSE_CYC);
        end
      end
      pfbi_pkg::PFBI_WR_PULSE: begin
        if (count_reg == 0) begin
          state_next = pfbi_pkg::PFBI_WR_HOLD;
          count_next = `PFBI_CNT_W'(`PFBI_SETUP_CYC);
        end
      end
      pfbi_pkg::PFBI_WR_HOLD: begin
        if (count_reg == 0) begin
          state_next = pfbi_pkg::PFBI_IDLE;
          count_next = `PFBI_CNT_W'(0);
        end
      end
      pfbi_pkg::PFBI_RST_PULSE: begin
        if (count_reg == 0) begin
          state_next = pfbi_pkg::PFBI_RST_WAIT;
          count_next = `PFBI_CNT_W'(`PFBI_READY_WAIT_CYC);
        end
      end
      pfbi_pkg::PFBI_RST_WAIT: begin
        if (ready_sync || count_reg == 0) begin
          state_next = pfbi_pkg::PFBI_IDLE;
          count_next = `PFBI_CNT_W'(`PFBI_RESET_RECOVERY_CYC);
        end
      end
      default: state_next = pfbi_pkg::PFBI_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= pfbi_pkg::PFBI_IDLE;
      count_reg <= `PFBI_CNT_W'(0);
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Reset recovery hold-off for reads
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      recovery_reg <= 1'b0;
    end else if (state_reg == pfbi_pkg::PFBI_RST_WAIT && state_next == pfbi_pkg::PFBI_IDLE) begin
      recovery_reg <= 1'b1;
    end else if (state_reg == pfbi_pkg::PFBI_IDLE && count_reg == 0) begin
      recovery_reg <= 1'b0;
    end
  end

  // Control pins
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      chip_sel_n_o <= 1'b1;
      out_en_n_o <= 1'b1;
      wr_strobe_n_o <= 1'b1;
      flash_reset_n_o <= 1'b1;
    end else begin
      chip_sel_n_o <= !(state_next == pfbi_pkg::PFBI_RD_ACCESS ||
        state_next == pfbi_pkg::PFBI_WR_SETUP || state_next == pfbi_pkg::PFBI_WR_PULSE ||
        state_next == pfbi_pkg::PFBI_WR_HOLD);
      out_en_n_o <= state_next != pfbi_pkg::PFBI_RD_ACCESS;
      wr_strobe_n_o <= state_next != pfbi_pkg::PFBI_WR_PULSE;
      flash_reset_n_o <= state_next != pfbi_pkg::PFBI_RST_PULSE;
    end
  end

  // Address and data pins
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      width_word_o <= 1'b1;
      addr_o <= 19'h0_0000;
      dq_out_o <= 16'h0000;
      dq_oe_o <= 16'h0000;
      sector_o <= 5'h00;
    end else if (state_reg == pfbi_pkg::PFBI_IDLE && state_next != pfbi_pkg::PFBI_IDLE &&
                 state_next != pfbi_pkg::PFBI_RST_PULSE) begin
      width_word_o <= !byte_mode_i;
      sector_o <= sector_of(byte_mode_i ? addr_i[19:13] : addr_i[18:12], boot_top_i);
      if (byte_mode_i) begin
        addr_o <= addr_i[19:1];
        dq_out_o <= {addr_i[0], 7'h00, wdata_i[7:0]};
        dq_oe_o <= {1'b1, 7'h00, {8{wr_req_i}}};
      end else begin
        addr_o <= addr_i[18:0];
        dq_out_o <= wdata_i;
        dq_oe_o <= {16{wr_req_i}};
      end
    end else if (state_next == pfbi_pkg::PFBI_IDLE || state_next == pfbi_pkg::PFBI_RST_PULSE) begin
      dq_oe_o <= 16'h0000;
    end
  end

  // Status and read data toward the user
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
      rd_valid_o <= 1'b0;
      wr_done_o <= 1'b0;
      rdata_o <= 16'h0000;
      flash_busy_o <= 1'b0;
    end else begin
      busy_o <= state_next != pfbi_pkg::PFBI_IDLE;
      flash_busy_o <= !ready_sync;
      rd_valid_o <= state_reg == pfbi_pkg::PFBI_RD_ACCESS && count_reg == 0;
      wr_done_o <= state_reg == pfbi_pkg::PFBI_WR_HOLD && count_reg == 0;
      if (state_reg == pfbi_pkg::PFBI_RD_ACCESS && count_reg == 0) begin
        rdata_o <= width_word_o ? dq_in_i : {8'h00, dq_in_i[7:0]};
      end
    end
  end

  // Length of the current flash reset pulse
  logic [`PFBI_CNT_W-1:0] rst_len_reg;
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || flash_reset_n_o) begin
      rst_len_reg <= `PFBI_CNT_W'(0);
    end else begin
      rst_len_reg <= rst_len_reg + `PFBI_CNT_W'(1);
    end
  end

  rd_pins_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !out_en_n_o |-> !chip_sel_n_o && wr_strobe_n_o) else $error("Read pins wrong");
  wr_pins_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !wr_strobe_n_o |-> !chip_sel_n_o && out_en_n_o) else $error("Write pins wrong");
  no_clash_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !out_en_n_o |-> dq_oe_o[14:0] == 15'h0000 && dq_oe_o[15] != width_word_o)
    else $error("Bus contention");
  rst_width_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $fell(flash_reset_n_o) |-> !flash_reset_n_o [*8]) else $error("Reset too short");
  rst_len_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(flash_reset_n_o) |-> rst_len_reg >= `PFBI_CNT_W'(`PFBI_RESET_PULSE_MIN_CYC))
    else $error("Reset pulse below minimum");
  rst_idle_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !flash_reset_n_o |-> chip_sel_n_o) else $error("Selected in reset");
  rd_time_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $fell(out_en_n_o) |-> !out_en_n_o [*8]) else $error("Read too short");
  byte_pin_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !width_word_o && !chip_sel_n_o |-> dq_oe_o[15] && dq_oe_o[14:8] == 7'h00)
    else $error("Byte mode lanes wrong");
  rd_done_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(out_en_n_o) && state_reg == pfbi_pkg::PFBI_IDLE |-> rd_valid_o)
    else $error("Read not answered");
endmodule : pfbi_host

/* File: pfbi_consts.svh */
// Timing counts and field positions for the parallel flash host controller
// Assumes a 100 MHz controller clock
`ifndef PFBI_CONSTS_SVH
`define PFBI_CONSTS_SVH
`define PFBI_CLK_PERIOD_NS 10
`define PFBI_ACCESS_TIME_NS 120
`define PFBI_ACCESS_CYC ((`PFBI_ACCESS_TIME_NS + `PFBI_CLK_PERIOD_NS - 1) / `PFBI_CLK_PERIOD_NS)
`define PFBI_WE_PULSE_NS 50
`define PFBI_WE_PULSE_CYC ((`PFBI_WE_PULSE_NS + `PFBI_CLK_PERIOD_NS - 1) / `PFBI_CLK_PERIOD_NS)
`define PFBI_SETUP_NS 20
`define PFBI_SETUP_CYC ((`PFBI_SETUP_NS + `PFBI_CLK_PERIOD_NS - 1) / `PFBI_CLK_PERIOD_NS)
`define PFBI_RESET_PULSE_MIN_NS 500
`define PFBI_RESET_PULSE_MIN_CYC ((`PFBI_RESET_PULSE_MIN_NS + `PFBI_CLK_PERIOD_NS - 1) / `PFBI_CLK_PERIOD_NS)
`define PFBI_RESET_RECOVERY_TIME_NS 50
`define PFBI_RESET_RECOVERY_CYC ((`PFBI_RESET_RECOVERY_TIME_NS + `PFBI_CLK_PERIOD_NS - 1) / `PFBI_CLK_PERIOD_NS)
`define PFBI_READY_WAIT_NS 20000
`define PFBI_READY_WAIT_CYC ((`PFBI_READY_WAIT_NS + `PFBI_CLK_PERIOD_NS - 1) / `PFBI_CLK_PERIOD_NS)
`define PFBI_ADDR_W 19
`define PFBI_DATA_W 16
`define PFBI_CNT_W 12
`define PFBI_SECT_HI 18
`define PFBI_SECT_LO 12
`endif

/* File: pfbi_pkg.sv */
// Types for the parallel flash host controller
// Assumes pfbi_consts.svh is compiled alongside
package pfbi_pkg;
  typedef enum logic [2:0] {
    PFBI_IDLE,
    PFBI_RD_ACCESS,
    PFBI_WR_SETUP,
    PFBI_WR_PULSE,
    PFBI_WR_HOLD,
    PFBI_RST_PULSE,
    PFBI_RST_WAIT
  } pfbi_state_type;
endpackage : pfbi_pkg

/* File: pfbi_sync.sv */
// Three-stage synchroniser for one pin input
// Assumes the pin is asynchronous to ref_clk_i
`timescale 1ns/1ns
module pfbi_sync (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] stage_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      stage_reg <= 3'h7;
    end else begin
      stage_reg <= {stage_reg[1:0], pin_i};
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      level_o <= 1'b1;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level_o <= stage_reg[2];
    end
  end
endmodule : pfbi_sync

/* File: pfbi_flash_model.sv */
// Behavioural flash at the far side of the host controller
// Assumes the bench resolves the shared data lines into dq_i
`timescale 1ns/1ns
module pfbi_flash_model (
  input wire logic chip_sel_n_i,
  input wire logic out_en_n_i,
  input wire logic wr_strobe_n_i,
  input wire logic reset_n_i,
  input wire logic width_word_i,
  input wire logic [18:0] addr_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic ready_busy_n_o
);
  logic [15:0] word;
  logic [15:0] rd;
  logic [15:0] noise = 16'h1234;
  logic drive;
  logic drv_d;
  time busy_until = 0;
  // Released lines wander
  always #7 noise = {noise[14:0], noise[15] ^ noise[13]};
  // Array contents, readable only while not busy
  assign word = addr_i[15:0] ^ 16'h5a5a;
  // Output gating
  assign drive = !chip_sel_n_i && !out_en_n_i && wr_strobe_n_i && reset_n_i;
  assign #50 drv_d = drive;
  // Width and status selection
  assign rd = !ready_busy_n_o ? {noise[15:8], 8'h80} : width_word_i ? word :
    {noise[15:8], dq_i[15] ? word[15:8] : word[7:0]};
  assign dq_o = (drive && drv_d) ? rd : noise;
  // Data taken at the strobe release
  always @(posedge wr_strobe_n_i)
    if (!chip_sel_n_i && out_en_n_i && reset_n_i && dq_i[7:0] === 8'h30)
      busy_until = $time + 3000;
  // Reset aborts the operation
  always @(negedge reset_n_i)
    if ($time < busy_until) busy_until = $time + 1000;
  // Busy flag, unaffected by select
  always #5 ready_busy_n_o = $time >= busy_until;
endmodule : pfbi_flash_model

/* File: tb_parallel_flash_bus_interface.sv */
// Self-checking bench for the flash host controller
// Assumes pfbi_host and pfbi_flash_model are compiled before it
`timescale 1ns/1ns
module tb_parallel_flash_bus_interface;
  logic ref_clk_i = 0, reset_n_i = 0, byte_mode_i = 0, boot_top_i = 0;
  logic rd_req_i = 0, wr_req_i = 0, flash_reset_req_i = 0;
  logic [19:0] addr_i = 20'h0_0000;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] dq_in_i, flash_dq, dq_out_o, dq_oe_o, rdata_o;
  logic ready_busy_n_i, busy_o, rd_valid_o, wr_done_o, flash_busy_o, chip_sel_n_o;
  logic out_en_n_o, wr_strobe_n_o, flash_reset_n_o, width_word_o;
  logic [4:0] sector_o;
  logic [18:0] addr_o;
  logic [31:0] seed = 32'h0fdf_947a;
  int n_errors = 0, n_tests = 0, cyc;
  always #5 ref_clk_i = ~ref_clk_i;
  assign dq_in_i = (dq_oe_o & dq_out_o) | (~dq_oe_o & flash_dq);
  pfbi_host dut_u (.ref_clk_i, .reset_n_i, .byte_mode_i, .boot_top_i, .rd_req_i,
    .wr_req_i, .flash_reset_req_i, .addr_i, .wdata_i, .dq_in_i, .ready_busy_n_i,
    .busy_o, .rd_valid_o, .wr_done_o, .rdata_o, .sector_o, .flash_busy_o,
    .chip_sel_n_o, .out_en_n_o, .wr_strobe_n_o, .flash_reset_n_o, .width_word_o,
    .addr_o, .dq_out_o, .dq_oe_o);
  pfbi_flash_model flash_u (.chip_sel_n_i(chip_sel_n_o), .out_en_n_i(out_en_n_o),
    .wr_strobe_n_i(wr_strobe_n_o), .reset_n_i(flash_reset_n_o),
    .width_word_i(width_word_o), .addr_i(addr_o), .dq_i(dq_in_i), .dq_o(flash_dq),
    .ready_busy_n_o(ready_busy_n_i));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [4:0] sect(input logic [18:0] a, input logic top);
    if (top) begin
      if (a[18:15] != 4'hf) return {1'b0, a[18:15]};
      if (!a[14]) return 5'h0f;
      if (!a[13]) return 5'h10 + a[12];
      return 5'h12;
    end
    if (a[18:15] != 4'h0) return a[18:15] + 5'h03;
    if (a[14]) return 5'h03;
    if (a[13]) return 5'h01 + a[12];
    return 5'h00;
  endfunction : sect
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // Kind 0 read, 1 write, 2 flash reset
  task automatic xfer(input int kind, input logic [19:0] a, input logic bm,
    input logic [15:0] d);
    logic [18:0] pins;
    logic [15:0] w;
    pins = bm ? a[19:1] : a[18:0];
    w = pins[15:0] ^ 16'h5a5a;
    @(negedge ref_clk_i);
    addr_i = a;
    byte_mode_i = bm;
    wdata_i = d;
    rd_req_i = kind == 0;
    wr_req_i = kind == 1;
    flash_reset_req_i = kind == 2;
    @(negedge ref_clk_i);
    {rd_req_i, wr_req_i, flash_reset_req_i} = 3'h0;
    for (cyc = 0; cyc < 3000; cyc++) begin
      @(posedge ref_clk_i);
      #1;
      if (cyc == 4 && kind == 0) begin
        chk({chip_sel_n_o, out_en_n_o, wr_strobe_n_o}, 3'h1);
        chk(dq_oe_o, bm ? 16'h8000 : 16'h0000);
        chk({width_word_o, addr_o, dq_out_o[15] & bm}, {!bm, pins, a[0] & bm});
      end
      if (cyc == 4 && kind == 1) begin
        chk({chip_sel_n_o, out_en_n_o, wr_strobe_n_o}, 3'h2);
        chk({dq_oe_o, dq_out_o}, {16'hffff, d});
      end
      if (cyc == 4 && kind == 2) chk(flash_reset_n_o, 1'b0);
      if (kind == 0 ? rd_valid_o : kind == 1 ? wr_done_o : !busy_o) break;
    end
    if (kind == 0) begin
      chk(cyc + 1, 13);
      chk(rdata_o, bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w);
      chk(sector_o, sect(pins, boot_top_i));
    end
    if (kind == 1) chk(cyc + 1, 12);
    if (kind == 2) chk({cyc >= 51, cyc < 3000}, 2'h3);
    if (kind == 2) repeat (6) @(posedge ref_clk_i);
  endtask : xfer
  initial begin
    #500_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    reset_n_i = 1;
    @(negedge ref_clk_i);
    chk({chip_sel_n_o, out_en_n_o, wr_strobe_n_o, flash_reset_n_o, dq_oe_o}, 20'hf_0000);
    for (int i = 0; i < 256; i++) begin
      seed = xs(seed);
      boot_top_i = i[7];
      if (seed[18]) xfer(0, {i[6:0], seed[12:0]}, 1'b1, 16'h0000);
      else xfer(0, {seed[19], i[6:0], seed[11:0]}, 1'b0, 16'h0000);
    end
    chk(chip_sel_n_o, 1'b1);
    xfer(1, 20'h1_2345, 1'b0, 16'h00f0);
    repeat (10) @(posedge ref_clk_i);
    chk(flash_busy_o, 1'b0);
    xfer(1, 20'h2_0000, 1'b0, 16'h0030);
    repeat (10) @(posedge ref_clk_i);
    chk(flash_busy_o, 1'b1);
    xfer(2, 20'h0_0000, 1'b0, 16'h0000);
    chk(flash_busy_o, 1'b0);
    xfer(0, 20'h2_0002, 1'b0, 16'h0000);
    xfer(1, 20'h2_0000, 1'b0, 16'h0030);
    repeat (10) @(posedge ref_clk_i);
    chk(flash_busy_o, 1'b1);
    repeat (300) @(posedge ref_clk_i);
    chk(flash_busy_o, 1'b0);
    xfer(2, 20'h0_0000, 1'b0, 16'h0000);
    xfer(0, 20'h7_f001, 1'b1, 16'h0000);
    end_of_test();
  end
endmodule : tb_parallel_flash_bus_interface
